// ---- jtag_tap_regs.vh ----
`ifndef JTAG_TAP_REGS_VH
`define JTAG_TAP_REGS_VH

// Controller state codes
`define TAP_TLR     4'h0
`define TAP_RTI     4'h1
`define TAP_SEL_DR  4'h2
`define TAP_CAP_DR  4'h3
`define TAP_SH_DR   4'h4
`define TAP_EX1_DR  4'h5
`define TAP_PA_DR   4'h6
`define TAP_EX2_DR  4'h7
`define TAP_UPD_DR  4'h8
`define TAP_SEL_IR  4'h9
`define TAP_CAP_IR  4'hA
`define TAP_SH_IR   4'hB
`define TAP_EX1_IR  4'hC
`define TAP_PA_IR   4'hD
`define TAP_EX2_IR  4'hE
`define TAP_UPD_IR  4'hF

// Register lengths
`define IR_LEN      10
`define ID_LEN      32
`define BOOT_LEN    22
`define CELL_LEN    3

// Bit positions inside one boundary cell
`define CELL_IN     0
`define CELL_OE     1
`define CELL_OUT    2

// Fixed value loaded when the instruction register captures
`define IR_CAPTURE  10'h155

// Instruction codes
`define I_SAMPLE    10'h005
`define I_EXTEST    10'h00F
`define I_BYPASS    10'h3FF
`define I_USERCODE  10'h007
`define I_IDCODE    10'h006
`define I_HIGHZ     10'h00B
`define I_CLAMP     10'h00A
`define I_PULSE     10'h001
`define I_CFG_IO    10'h00D
`define I_CLK_USER  10'h1EE
`define I_CLK_OSC   10'h2EE
`define I_DISENGAGE 10'h2D0
`define I_ENGAGE    10'h2B0
`define I_BOOT_ADDR 10'h270

`endif

// ---- tap_sync2.v ----
`timescale 1ns/1ns
// Two-stage synchroniser; only the second stage is visible outside
module tap_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             clk_i,
    input  wire             srst_i,
    input  wire [WIDTH-1:0] d_i,
    output wire [WIDTH-1:0] q_o
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    always @(posedge clk_i) begin
        if (srst_i) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end

    assign q_o = sync_ff;
endmodule

// ---- tap_fsm.v ----
`timescale 1ns/1ns
`include "jtag_tap_regs.vh"
module tap_fsm (
    input  wire       clk_i,
    input  wire       srst_i,
    input  wire       step_i,
    input  wire       tms_i,
    output wire [3:0] state_o
);
    localparam ST_TLR    = `TAP_TLR;
    localparam ST_RTI    = `TAP_RTI;
    localparam ST_SEL_DR = `TAP_SEL_DR;
    localparam ST_CAP_DR = `TAP_CAP_DR;
    localparam ST_SH_DR  = `TAP_SH_DR;
    localparam ST_EX1_DR = `TAP_EX1_DR;
    localparam ST_PA_DR  = `TAP_PA_DR;
    localparam ST_EX2_DR = `TAP_EX2_DR;
    localparam ST_UPD_DR = `TAP_UPD_DR;
    localparam ST_SEL_IR = `TAP_SEL_IR;
    localparam ST_CAP_IR = `TAP_CAP_IR;
    localparam ST_SH_IR  = `TAP_SH_IR;
    localparam ST_EX1_IR = `TAP_EX1_IR;
    localparam ST_PA_IR  = `TAP_PA_IR;
    localparam ST_EX2_IR = `TAP_EX2_IR;
    localparam ST_UPD_IR = `TAP_UPD_IR;

    reg [3:0] state_ff;
    reg [3:0] nxt_state;

    // Five steps with select high reach reset from every state
    always @* begin
        case (state_ff)
            ST_TLR:    nxt_state = tms_i ? ST_TLR    : ST_RTI;
            ST_RTI:    nxt_state = tms_i ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: nxt_state = tms_i ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: nxt_state = tms_i ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  nxt_state = tms_i ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: nxt_state = tms_i ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR:  nxt_state = tms_i ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: nxt_state = tms_i ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: nxt_state = tms_i ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: nxt_state = tms_i ? ST_TLR    : ST_CAP_IR;
            ST_CAP_IR: nxt_state = tms_i ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  nxt_state = tms_i ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: nxt_state = tms_i ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR:  nxt_state = tms_i ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: nxt_state = tms_i ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: nxt_state = tms_i ? ST_SEL_DR : ST_RTI;
            default:   nxt_state = ST_TLR;
        endcase
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            state_ff <= ST_TLR;
        end else if (step_i) begin
            state_ff <= nxt_state;
        end
    end

    assign state_o = state_ff;
endmodule

// ---- boundary_scan_tap_instruction_decoder.v ----
// How it works
// - Sample captures pins, preload loads update cells
// - External test drives update cells, captures pins
// - Bypass puts one-bit register in scan path
// - User code shifts out 32-bit user register
// - Identification shifts out the identification register
// - Identification active after power-up and reset
// - High-impedance: bypass path, all user pins floated
// - Clamp: bypass path, pins held from update cells
// - Reconfiguration pulse fires internal reconfiguration request
// - I/O reconfiguration shifts the I/O config chain
// - Enable-user-clock selects the user configuration clock
// - Disable-user-clock returns to internal oscillator
// - Disengage forces configuration controllers idle
// - Engage re-engages the active configuration controller
// - Boot address: 22-bit register loads flash boot address
// - Bus-hold and pull-up stay on in test modes
// - Sixteen-state controller steps on rising test clock
// - Reset state: scan off, normal pins, identification
// - Controller starts in reset state at power-up
// - Five clocks with select high force reset
// - Select held high keeps controller in reset
// - Output changes on falling edge, floats otherwise
// - All-ones instruction selects bypass
// - Instruction capture shifts out fixed 1010101010 pattern
`timescale 1ns/1ns
`include "jtag_tap_regs.vh"
module boundary_scan_tap_instruction_decoder #(
    parameter NUM_PINS  = 201,
    parameter ID_VALUE  = 32'h0ABC_D001,  // Arbitrary value, bit 0 set
    parameter USER_CODE = 32'hFFFF_FFFF
) (
    input  wire                 clk_i,
    input  wire                 srst_i,
    input  wire                 tck_i,
    input  wire                 tms_i,
    input  wire                 tdi_i,
    output wire                 tdo_o,
    output wire                 tdo_oe_o,
    input  wire [NUM_PINS-1:0]  core_out_i,
    input  wire [NUM_PINS-1:0]  core_oe_i,
    input  wire [NUM_PINS-1:0]  pin_in_i,
    input  wire [NUM_PINS-1:0]  keeper_en_i,
    output wire [NUM_PINS-1:0]  pin_out_o,
    output wire [NUM_PINS-1:0]  pin_oe_o,
    output wire [NUM_PINS-1:0]  keeper_on_o,
    output wire                 reconfig_pulse_o,
    output wire                 io_config_sel_o,
    output wire                 io_config_shift_o,
    output wire                 io_config_tdi_o,
    input  wire                 io_config_tdo_i,
    output wire                 user_config_clock_sel_o,
    output wire                 config_ctrl_idle_o,
    output wire [`BOOT_LEN-1:0] boot_addr_o,
    output wire                 boot_addr_load_o,
    output wire [`IR_LEN-1:0]   instr_o,
    output wire [3:0]           tap_state_o
);
    localparam BSR_LEN = `CELL_LEN * NUM_PINS;

    wire [2:0]          jtag_s;
    wire                tck_s;
    wire                tms_s;
    wire                tdi_s;
    wire [NUM_PINS-1:0] pin_in_s;
    wire [3:0]          state;
    wire                tck_rise;
    wire                tck_fall;
    reg                 tck_d_ff;

    // Test clock is far slower than clk_i, so sampling it is enough
    tap_sync2 #(
        .WIDTH (3)
    ) u_jtag_sync (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .d_i    ({tck_i, tms_i, tdi_i}),
        .q_o    (jtag_s)
    );

    tap_sync2 #(
        .WIDTH (NUM_PINS)
    ) u_pin_sync (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .d_i    (pin_in_i),
        .q_o    (pin_in_s)
    );

    assign tck_s    = jtag_s[2];
    assign tms_s    = jtag_s[1];
    assign tdi_s    = jtag_s[0];
    assign tck_rise = tck_s & ~tck_d_ff;
    assign tck_fall = ~tck_s & tck_d_ff;

    always @(posedge clk_i) begin
        if (srst_i) begin
            tck_d_ff <= 1'b0;
        end else begin
            tck_d_ff <= tck_s;
        end
    end

    tap_fsm u_fsm (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .step_i  (tck_rise),
        .tms_i   (tms_s),
        .state_o (state)
    );

    // Instruction register
    reg [`IR_LEN-1:0] ir_sh_ff;
    reg [`IR_LEN-1:0] instr_ff;

    always @(posedge clk_i) begin
        if (srst_i) begin
            ir_sh_ff <= `IR_CAPTURE;
            instr_ff <= `I_IDCODE;
        end else if (state == `TAP_TLR) begin
            instr_ff <= `I_IDCODE;
        end else if (tck_rise) begin
            case (state)
                `TAP_CAP_IR: begin
                    ir_sh_ff <= `IR_CAPTURE;
                end
                `TAP_SH_IR: begin
                    ir_sh_ff <= {tdi_s, ir_sh_ff[`IR_LEN-1:1]};
                end
                `TAP_UPD_IR: begin
                    instr_ff <= ir_sh_ff;
                end
                default: begin
                    instr_ff <= instr_ff;
                end
            endcase
        end
    end

    // Full ten-bit compares, so truncated look-alikes fall to bypass
    wire sel_sample = (instr_ff == `I_SAMPLE);
    wire sel_extest = (instr_ff == `I_EXTEST);
    wire sel_user   = (instr_ff == `I_USERCODE);
    wire sel_id     = (instr_ff == `I_IDCODE);
    wire sel_highz  = (instr_ff == `I_HIGHZ);
    wire sel_clamp  = (instr_ff == `I_CLAMP);
    wire sel_cfg_io = (instr_ff == `I_CFG_IO);
    wire sel_boot   = (instr_ff == `I_BOOT_ADDR);
    wire sel_bsr    = sel_sample | sel_extest;
    wire sel_idreg  = sel_user | sel_id;
    // Everything else, all-ones included, uses the one-bit path
    wire sel_bypass = ~(sel_bsr | sel_idreg | sel_cfg_io | sel_boot);

    // Data registers
    reg                 bypass_ff;
    reg [`ID_LEN-1:0]   id_sh_ff;
    reg [`BOOT_LEN-1:0] boot_sh_ff;
    reg [`BOOT_LEN-1:0] boot_addr_ff;
    reg                 boot_load_ff;
    reg [BSR_LEN-1:0]   bsr_sh_ff;
    reg [BSR_LEN-1:0]   bsr_upd_ff;
    reg                 io_config_shift_register_shift_ff;
    reg                 io_config_shift_register_tdi_ff;
    wire [BSR_LEN-1:0]  bsr_cap;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_cap
            assign bsr_cap[`CELL_LEN*gi+`CELL_IN]  = pin_in_s[gi];
            assign bsr_cap[`CELL_LEN*gi+`CELL_OE]  = core_oe_i[gi];
            assign bsr_cap[`CELL_LEN*gi+`CELL_OUT] = core_out_i[gi];
        end
    endgenerate

    always @(posedge clk_i) begin
        if (srst_i) begin
            bypass_ff      <= 1'b0;
            id_sh_ff       <= {`ID_LEN{1'b0}};
            boot_sh_ff     <= {`BOOT_LEN{1'b0}};
            boot_addr_ff   <= {`BOOT_LEN{1'b0}};
            boot_load_ff   <= 1'b0;
            bsr_sh_ff      <= {BSR_LEN{1'b0}};
            bsr_upd_ff     <= {BSR_LEN{1'b0}};
            io_config_shift_register_shift_ff <= 1'b0;
            io_config_shift_register_tdi_ff   <= 1'b0;
        end else begin
            boot_load_ff   <= 1'b0;
            io_config_shift_register_shift_ff <= 1'b0;
            if (tck_rise) begin
                case (state)
                    `TAP_CAP_DR: begin
                        bypass_ff  <= 1'b0;
                        id_sh_ff   <= sel_user ? USER_CODE : ID_VALUE;
                        boot_sh_ff <= boot_addr_ff;
                        if (sel_bsr) begin
                            bsr_sh_ff <= bsr_cap;
                        end
                    end
                    `TAP_SH_DR: begin
                        if (sel_bypass) begin
                            bypass_ff <= tdi_s;
                        end
                        if (sel_idreg) begin
                            id_sh_ff <= {tdi_s, id_sh_ff[`ID_LEN-1:1]};
                        end
                        if (sel_boot) begin
                            boot_sh_ff <= {tdi_s, boot_sh_ff[`BOOT_LEN-1:1]};
                        end
                        if (sel_bsr) begin
                            bsr_sh_ff <= {tdi_s, bsr_sh_ff[BSR_LEN-1:1]};
                        end
                        if (sel_cfg_io) begin
                            io_config_shift_register_shift_ff <= 1'b1;
                            io_config_shift_register_tdi_ff   <= tdi_s;
                        end
                    end
                    `TAP_UPD_DR: begin
                        if (sel_bsr) begin
                            bsr_upd_ff <= bsr_sh_ff;
                        end
                        if (sel_boot) begin
                            boot_addr_ff <= boot_sh_ff;
                            boot_load_ff <= 1'b1;
                        end
                    end
                    default: begin
                        bypass_ff <= bypass_ff;
                    end
                endcase
            end
        end
    end

    // Configuration side effects, taken when an instruction is updated
    reg reconfig_ff;
    reg clk_user_ff;
    reg ctrl_idle_ff;
    reg cfg_io_sel_ff;

    always @(posedge clk_i) begin
        if (srst_i) begin
            reconfig_ff   <= 1'b0;
            clk_user_ff   <= 1'b0;
            ctrl_idle_ff  <= 1'b0;
            cfg_io_sel_ff <= 1'b0;
        end else begin
            reconfig_ff   <= 1'b0;
            cfg_io_sel_ff <= sel_cfg_io;
            if (tck_rise && (state == `TAP_UPD_IR)) begin
                case (ir_sh_ff)
                    `I_PULSE: begin
                        reconfig_ff <= 1'b1;
                    end
                    `I_CLK_USER: begin
                        clk_user_ff <= 1'b1;
                    end
                    `I_CLK_OSC: begin
                        clk_user_ff <= 1'b0;
                    end
                    `I_DISENGAGE: begin
                        ctrl_idle_ff <= 1'b1;
                    end
                    `I_ENGAGE: begin
                        ctrl_idle_ff <= 1'b0;
                    end
                    default: begin
                        clk_user_ff <= clk_user_ff;
                    end
                endcase
            end
        end
    end

    // Pin control; in test-logic reset the identification code keeps core paths
    reg [NUM_PINS-1:0] pin_out_ff;
    reg [NUM_PINS-1:0] pin_oe_ff;
    reg [NUM_PINS-1:0] keeper_ff;
    wire               drive_upd = sel_extest | sel_clamp;

    generate
        for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
            always @(posedge clk_i) begin
                if (srst_i) begin
                    pin_out_ff[gi] <= 1'b0;
                    pin_oe_ff[gi]  <= 1'b0;
                    keeper_ff[gi]  <= 1'b0;
                end else begin
                    // Keepers stay on even while the pin floats
                    keeper_ff[gi] <= keeper_en_i[gi];
                    if (sel_highz) begin
                        pin_out_ff[gi] <= 1'b0;
                        pin_oe_ff[gi]  <= 1'b0;
                    end else if (drive_upd) begin
                        pin_out_ff[gi] <= bsr_upd_ff[`CELL_LEN*gi+`CELL_OUT];
                        pin_oe_ff[gi]  <= bsr_upd_ff[`CELL_LEN*gi+`CELL_OE];
                    end else begin
                        pin_out_ff[gi] <= core_out_i[gi];
                        pin_oe_ff[gi]  <= core_oe_i[gi];
                    end
                end
            end
        end
    endgenerate

    // Serial output, updated only on falling test clock edges
    reg tdo_ff;
    reg tdo_oe_ff;
    reg tdo_nxt;

    always @* begin
        if (state == `TAP_SH_IR) begin
            tdo_nxt = ir_sh_ff[0];
        end else if (sel_bsr) begin
            tdo_nxt = bsr_sh_ff[0];
        end else if (sel_idreg) begin
            tdo_nxt = id_sh_ff[0];
        end else if (sel_boot) begin
            tdo_nxt = boot_sh_ff[0];
        end else if (sel_cfg_io) begin
            tdo_nxt = io_config_tdo_i;
        end else begin
            tdo_nxt = bypass_ff;
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            tdo_ff    <= 1'b0;
            tdo_oe_ff <= 1'b0;
        end else if (tck_fall) begin
            tdo_ff    <= tdo_nxt;
            tdo_oe_ff <= (state == `TAP_SH_IR) || (state == `TAP_SH_DR);
        end
    end

    // State and instruction are registered once more before being sent out
    reg [3:0]         state_ff;
    reg [`IR_LEN-1:0] instr_out_ff;

    always @(posedge clk_i) begin
        if (srst_i) begin
            state_ff     <= `TAP_TLR;
            instr_out_ff <= `I_IDCODE;
        end else begin
            state_ff     <= state;
            instr_out_ff <= instr_ff;
        end
    end

    assign tdo_o                   = tdo_ff;
    assign tdo_oe_o                = tdo_oe_ff;
    assign pin_out_o               = pin_out_ff;
    assign pin_oe_o                = pin_oe_ff;
    assign keeper_on_o             = keeper_ff;
    assign reconfig_pulse_o        = reconfig_ff;
    assign io_config_sel_o         = cfg_io_sel_ff;
    assign io_config_shift_o       = io_config_shift_register_shift_ff;
    assign io_config_tdi_o         = io_config_shift_register_tdi_ff;
    assign user_config_clock_sel_o = clk_user_ff;
    assign config_ctrl_idle_o      = ctrl_idle_ff;
    assign boot_addr_o             = boot_addr_ff;
    assign boot_addr_load_o        = boot_load_ff;
    assign instr_o                 = instr_out_ff;
    assign tap_state_o             = state_ff;
endmodule

// ---- tap_decoder_asserts.sv ----
`timescale 1ns/1ns
`include "jtag_tap_regs.vh"
module tap_decoder_asserts #(
    parameter NUM_PINS = 201
) (
    input wire                 clk_i,
    input wire                 srst_i,
    input wire                 tck_i,
    input wire                 tdo_o,
    input wire                 tdo_oe_o,
    input wire [NUM_PINS-1:0]  core_out_i,
    input wire [NUM_PINS-1:0]  core_oe_i,
    input wire [NUM_PINS-1:0]  keeper_en_i,
    input wire [NUM_PINS-1:0]  pin_out_o,
    input wire [NUM_PINS-1:0]  pin_oe_o,
    input wire [NUM_PINS-1:0]  keeper_on_o,
    input wire                 reconfig_pulse_o,
    input wire                 io_config_sel_o,
    input wire                 io_config_shift_o,
    input wire                 boot_addr_load_o,
    input wire [`IR_LEN-1:0]   instr_o,
    input wire [3:0]           tap_state_o
);
    // Successors {tms low, tms high} of each state, one byte per state
    localparam [127:0] SUCC = 128'h12BF_DEDF_BCBC_A012_4867_6845_4539_1210;
    logic [3:0] prev_ff;
    always @(posedge clk_i) prev_ff <= tap_state_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    AST_FSM_STEP: assert property (
        tap_state_o != prev_ff |-> tap_state_o == SUCC[8*prev_ff +: 4]
            || tap_state_o == SUCC[8*prev_ff+4 +: 4])
        else $error("Controller moved to an illegal state");
    AST_TDO_ON_FALL: assert property (
        $changed(tdo_o) |-> !tck_i && !$past(tck_i, 2))
        else $error("Serial output changed outside a low test clock phase");
    AST_OE_SHIFT: assert property (
        tdo_oe_o |-> tap_state_o inside {`TAP_SH_DR, `TAP_EX1_DR, `TAP_SH_IR, `TAP_EX1_IR})
        else $error("Serial output enabled outside shifting");
    AST_TLR_IDCODE: assert property (
        tap_state_o == `TAP_TLR && prev_ff == `TAP_TLR |=> instr_o == `I_IDCODE)
        else $error("Reset state without identification instruction");
    AST_HIGHZ_FLOAT: assert property (
        instr_o == `I_HIGHZ && $past(instr_o) == `I_HIGHZ |-> ~|pin_oe_o)
        else $error("Pin enabled under high impedance");
    AST_KEEPER: assert property (
        !$past(srst_i) |-> keeper_on_o == $past(keeper_en_i))
        else $error("Keeper output does not follow its enable");
    AST_CORE_PINS: assert property (
        !$past(srst_i) && $stable(instr_o)
            && !(instr_o inside {`I_HIGHZ, `I_CLAMP, `I_EXTEST})
        |-> pin_out_o == $past(core_out_i) && pin_oe_o == $past(core_oe_i))
        else $error("Pins do not follow the core in normal mode");
    AST_PULSE_ONE: assert property (
        reconfig_pulse_o |=> !reconfig_pulse_o && instr_o == `I_PULSE)
        else $error("Reconfiguration pulse malformed");
    AST_BOOT_LOAD: assert property (
        boot_addr_load_o |=> !boot_addr_load_o && instr_o == `I_BOOT_ADDR)
        else $error("Boot address load outside its instruction");
    AST_IO_SHIFT: assert property (
        io_config_shift_o |-> io_config_sel_o && instr_o == `I_CFG_IO)
        else $error("I/O chain shifted outside its instruction");
    COV_PULSE: cover property (reconfig_pulse_o);
    COV_BOOT: cover property (boot_addr_load_o);
    COV_UPD_IR: cover property (tap_state_o == `TAP_UPD_IR);
endmodule

bind boundary_scan_tap_instruction_decoder tap_decoder_asserts #(.NUM_PINS(NUM_PINS)) chk (
    .clk_i, .srst_i, .tck_i, .tdo_o, .tdo_oe_o, .core_out_i, .core_oe_i, .keeper_en_i,
    .pin_out_o, .pin_oe_o, .keeper_on_o, .reconfig_pulse_o, .io_config_sel_o,
    .io_config_shift_o, .boot_addr_load_o, .instr_o, .tap_state_o);

// ---- tap_host_model.sv ----
`timescale 1ns/1ns
module tap_host_model (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input  wire  tdo_i,
    input  wire  tdo_oe_i
);
    logic last;
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        last = 1'b0;
    end
    // Test clock stands low between calls; long low phase lets the output settle
    task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe);
        tms_o = tms;
        tdi_o = tdi;
        #20 tck_o = 1'b1;
        #60 tck_o = 1'b0;
        #80;
        oe = tdo_oe_i;
        // A released line reads as the inverse of its last level
        tdo = tdo_oe_i ? tdo_i : ~last;
        last = tdo;
    endtask
    task automatic force_reset(output logic tdo, output logic oe);
        repeat (5) step(1'b1, 1'b0, tdo, oe);
    endtask
endmodule

// ---- boundary_scan_tap_instruction_decoder_bench.sv ----
`timescale 1ns/1ns
`include "jtag_tap_regs.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
    $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
module boundary_scan_tap_instruction_decoder_bench;
    localparam [31:0] ID_V = 32'h0246_8ACF;  // Arbitrary value
    localparam [31:0] UC_V = 32'h5A5A_0F0F;
    logic        clk_i, srst_i, tck, tms, tdi, tdo, tdo_oe, t, oe, io_tdo;
    logic        pulse, io_sel, io_shift, io_tdi, clk_sel, idle, boot_load;
    logic [1:0]  core_out, core_oe, pin_in, keeper_en, pin_out, pin_oe, keeper_on;
    logic [21:0] boot_addr;
    logic [9:0]  instr;
    logic [3:0]  tap_state, io_bits;
    int          n_mismatch = 0, checks_done = 0, n_pulse = 0, n_boot = 0, n_ioshift = 0;
    boundary_scan_tap_instruction_decoder #(.NUM_PINS(2), .ID_VALUE(ID_V), .USER_CODE(UC_V)) DUT (
        .clk_i(clk_i), .srst_i(srst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .tdo_o(tdo), .tdo_oe_o(tdo_oe), .core_out_i(core_out), .core_oe_i(core_oe),
        .pin_in_i(pin_in), .keeper_en_i(keeper_en), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
        .keeper_on_o(keeper_on), .reconfig_pulse_o(pulse), .io_config_sel_o(io_sel),
        .io_config_shift_o(io_shift), .io_config_tdi_o(io_tdi), .io_config_tdo_i(io_tdo),
        .user_config_clock_sel_o(clk_sel), .config_ctrl_idle_o(idle),
        .boot_addr_o(boot_addr), .boot_addr_load_o(boot_load), .instr_o(instr),
        .tap_state_o(tap_state));
    tap_host_model host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Counted on the falling edge, where the pulses have settled
    always @(negedge clk_i) begin
        n_pulse += (pulse === 1'b1);
        n_boot += (boot_load === 1'b1);
        n_ioshift += (io_shift === 1'b1);
        if (io_shift === 1'b1) io_bits = {io_tdi, io_bits[3:1]};
    end
    task automatic walk(input logic [7:0] pat, input int n);
        for (int i = 0; i < n; i++) host.step(pat[i], 1'b0, t, oe);
    endtask
    task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
        dout = 32'h0;
        for (int i = 0; i < n; i++) begin
            dout[i] = t;
            `CHK(oe, 1'b1);
            host.step(i == n - 1, din[i], t, oe);
        end
    endtask
    task automatic ir(input logic [9:0] code);
        logic [31:0] cap;
        walk(8'h06, 5);
        shift(10, {22'h0, code}, cap);
        `CHK(cap[9:0], `IR_CAPTURE);
        walk(8'h01, 2);
        `CHK(oe, 1'b0);
        `CHK(instr, code);
    endtask
    task automatic dr(input int n, input logic [31:0] din, output logic [31:0] dout);
        walk(8'h02, 4);
        shift(n, din, dout);
        walk(8'h01, 2);
    endtask
    task automatic t_idcode();
        logic [31:0] d;
        `CHK(tap_state, `TAP_TLR);
        `CHK(instr, `I_IDCODE);
        dr(32, 32'h0, d);
        `CHK(d, ID_V);
        ir(`I_USERCODE);
        dr(32, 32'h0, d);
        `CHK(d, UC_V);
    endtask
    task automatic t_bsr();
        logic [31:0] d;
        ir(`I_SAMPLE);
        `CHK({pin_oe, pin_out}, {core_oe, core_out});
        dr(6, 32'h16, d);
        `CHK(d[5:0], 6'h31);
        @(negedge clk_i) pin_in = 2'b10;
        ir(`I_EXTEST);
        `CHK({pin_oe, pin_out}, 4'hD);
        dr(6, 32'h16, d);
        `CHK({d[3], d[0]}, 2'b10);
    endtask
    task automatic t_bypass();
        logic [9:0]  codes [9] = '{10'h3FF, 10'h2AA, `I_HIGHZ, `I_CLAMP, `I_PULSE,
                                   `I_CLK_USER, `I_CLK_OSC, `I_DISENGAGE, `I_ENGAGE};
        logic [31:0] d;
        logic [3:0]  pins;
        for (int k = 0; k < 9; k++) begin
            ir(codes[k]);
            pins = (k == 2) ? 4'h0 : (k == 3) ? 4'hD : {core_oe, core_out};
            `CHK({pin_oe, pin_out}, pins);
            `CHK(keeper_on, keeper_en);
            `CHK(clk_sel, k == 5);
            `CHK(idle, k == 7);
            `CHK(n_pulse, int'(k >= 4));
            dr(4, 32'hB, d);
            `CHK(d[3:0], 4'h6);
        end
    endtask
    task automatic t_boot();
        logic [31:0] d;
        ir(`I_BOOT_ADDR);
        dr(22, 32'h15A5A5, d);
        `CHK(d[21:0], 22'h0);
        `CHK(boot_addr, 22'h15A5A5);
        dr(22, 32'h0, d);
        `CHK(d[21:0], 22'h15A5A5);
        `CHK(n_boot, 2);
    endtask
    task automatic t_io();
        logic [31:0] d;
        @(negedge clk_i) io_tdo = 1'b1;
        ir(`I_CFG_IO); // issued once configuration status is taken as good
        `CHK(io_sel, 1'b1);
        dr(4, 32'h5, d);
        `CHK(d[3:0], 4'hF);
        `CHK(n_ioshift, 4);
        `CHK(io_bits, 4'h5);
    endtask
    task automatic t_tlr();
        walk(8'h02, 4);
        host.force_reset(t, oe);
        `CHK(tap_state, `TAP_TLR);
        `CHK(instr, `I_IDCODE);
        walk(8'hFF, 3);
        `CHK(tap_state, `TAP_TLR);
    endtask
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        // About 510 test clock periods (82 us) are needed; allow five times that
        #400000;
        n_mismatch++;
        summarize();
    end
    initial begin
        srst_i = 1'b1;
        core_out = 2'b10;
        core_oe = 2'b10;
        pin_in = 2'b01;
        keeper_en = 2'b01;
        io_tdo = 1'b0;
        repeat (10) @(negedge clk_i);
        srst_i = 1'b0;
        repeat (3) @(negedge clk_i);
        t_idcode();
        t_bsr();
        t_bypass();
        t_boot();
        t_io();
        t_tlr();
        summarize();
    end
endmodule
